// File: hdl/sdm_pkg.sv
package sdm_pkg;

	// ----------------------------------------------------------------
	// Pin widths (sixteen-bit organisation)
	// ----------------------------------------------------------------
	localparam int DQ_W      = 16;
	localparam int LANE_W    = 8;
	localparam int LANES     = 2;
	localparam int BA_W      = 2;
	localparam int BANKS     = 4;
	localparam int ADDR_W    = 12;
	localparam int COL_W     = 9;
	localparam int AP_BIT    = 10;

	// ----------------------------------------------------------------
	// Reduced storage array: bank, two row bits, four column bits
	// ----------------------------------------------------------------
	localparam int MEM_ROW_W = 2;
	localparam int MEM_COL_W = 4;
	localparam int MEM_AW    = BA_W + MEM_ROW_W + MEM_COL_W;
	localparam int MEM_DEPTH = 256;

	// ----------------------------------------------------------------
	// Latencies in clock cycles
	// ----------------------------------------------------------------
	localparam int READ_LAT  = 2;
	localparam int DQM_RD_LAT = 2;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam int          AXI_AW      = 8;
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_STATUS  = 8'h04;
	localparam logic [7:0]  REG_MODE    = 8'h08;
	localparam logic [7:0]  REG_MASKED  = 8'h0C;
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_BL_LSB = 1;
	localparam int          CTRL_BL_MSB = 2;
	localparam logic [7:0]  CTRL_RST    = 8'h01;
	localparam int          STAT_BST_LSB = 4;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Command code {ras_n, cas_n, we_n}; deselect maps to no-op
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR  = 3'h4,
		CMD_RD  = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} sdm_cmd_e;

	// Burst state, Gray along idle-read and idle-write
	typedef enum logic [1:0] {
		BS_IDLE  = 2'h0,
		BS_READ  = 2'h1,
		BS_WRITE = 2'h2
	} sdm_burst_e;

	// Turns the three command strobes into a command
	function automatic sdm_cmd_e sdm_decode(input logic ras_n, input logic cas_n,
			input logic we_n);
		return sdm_cmd_e'({ras_n, cas_n, we_n});
	endfunction

	// Column wrap mask for burst length code 1, 2, 4, 8
	function automatic logic [2:0] sdm_bl_mask(input logic [1:0] code);
		logic [2:0] m;
		m = 3'h0;
		unique case (code)
			2'h0: m = 3'h0;
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			2'h3: m = 3'h7;
		endcase
		return m;
	endfunction

endpackage

// File: hdl/sdm_mem_if.sv
`timescale 1ns/10ps

// Storage port between the pin logic and the array
interface sdm_mem_if;
	logic                                     we;
	logic [sdm_pkg::LANES-1:0]                lane_we;
	logic [sdm_pkg::MEM_AW-1:0]               waddr;
	logic [sdm_pkg::DQ_W-1:0]                 wdata;
	logic                                     re;
	logic [sdm_pkg::MEM_AW-1:0]               raddr;
	logic [sdm_pkg::DQ_W-1:0]                 rdata;

	modport ctl (output we, lane_we, waddr, wdata, re, raddr, input rdata);
	modport mem (input we, lane_we, waddr, wdata, re, raddr, output rdata);
endinterface

// File: hdl/sdm_mem.sv
`timescale 1ns/10ps

module sdm_mem (
	input  wire logic   i_clk,
	input  wire logic   i_nrst,
	sdm_mem_if.mem      mif
);

	typedef struct packed {
		logic [sdm_pkg::MEM_DEPTH-1:0][sdm_pkg::DQ_W-1:0] cells;
		logic [sdm_pkg::DQ_W-1:0]                         rdata;
	} sdm_mem_s;

	sdm_mem_s s_reg;
	sdm_mem_s s_next;

	// ----------------------------------------------------------------
	// Lane-wise write, registered read
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		if (mif.re) begin
			s_next.rdata = s_reg.cells[mif.raddr];
		end
		for (int l = 0; l < sdm_pkg::LANES; l++) begin
			if (mif.we && mif.lane_we[l]) begin
				s_next.cells[mif.waddr][l*sdm_pkg::LANE_W +: sdm_pkg::LANE_W] =
					mif.wdata[l*sdm_pkg::LANE_W +: sdm_pkg::LANE_W];
			end
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign mif.rdata = s_reg.rdata;

endmodule // sdm_mem

// File: hdl/sdm_pins.sv
`timescale 1ns/10ps

// Summary of operation
// - Masked write lane leaves stored data unchanged
// - Read mask floats outputs two clocks later
// - Low mask bits 7..0, high 15..8
// - Bank number picks the command's bank
// - Activate takes all twelve bits as row
// - Column width follows organisation; here bits 8..0
// - Auto-precharge bit selects precharge after burst
// - Precharge bit high closes all banks
// - Mode load takes address inputs as opcode
// - Data bus width matches organisation, sixteen here
// - Deselect ignores commands, bursts and masks continue
// - All inputs registered on rising clock edge

module sdm_pins (
	input  wire logic                          i_clk,
	input  wire logic                          i_nrst,
	input  wire logic                          i_cs_n,
	input  wire logic                          i_ras_n,
	input  wire logic                          i_cas_n,
	input  wire logic                          i_we_n,
	input  wire logic [sdm_pkg::BA_W-1:0]      i_ba,
	input  wire logic [sdm_pkg::ADDR_W-1:0]    i_addr,
	input  wire logic                          i_low_lane_mask,
	input  wire logic                          i_high_lane_mask,
	input  wire logic [sdm_pkg::DQ_W-1:0]      i_dq,
	output logic      [sdm_pkg::DQ_W-1:0]      o_dq,
	output logic      [sdm_pkg::DQ_W-1:0]      o_dq_oe_n,
	input  wire logic                          i_s_axi_awvalid,
	output logic                               o_s_axi_awready,
	input  wire logic [sdm_pkg::AXI_AW-1:0]    i_s_axi_awaddr,
	input  wire logic                          i_s_axi_wvalid,
	output logic                               o_s_axi_wready,
	input  wire logic [31:0]                   i_s_axi_wdata,
	input  wire logic [3:0]                    i_s_axi_wstrb,
	output logic                               o_s_axi_bvalid,
	input  wire logic                          i_s_axi_bready,
	output logic      [1:0]                    o_s_axi_bresp,
	input  wire logic                          i_s_axi_arvalid,
	output logic                               o_s_axi_arready,
	input  wire logic [sdm_pkg::AXI_AW-1:0]    i_s_axi_araddr,
	output logic                               o_s_axi_rvalid,
	input  wire logic                          i_s_axi_rready,
	output logic      [31:0]                   o_s_axi_rdata,
	output logic      [1:0]                    o_s_axi_rresp
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                                              cs_n;
		logic                                              ras_n;
		logic                                              cas_n;
		logic                                              we_n;
		logic [sdm_pkg::BA_W-1:0]                          ba;
		logic [sdm_pkg::ADDR_W-1:0]                        addr;
		logic [sdm_pkg::LANES-1:0]                         dqm;
		logic [sdm_pkg::DQ_W-1:0]                          dq;
		logic [sdm_pkg::LANES-1:0]                         dqm_d1;
		logic [sdm_pkg::BANKS-1:0]                         active;
		logic [sdm_pkg::BANKS-1:0][sdm_pkg::ADDR_W-1:0]    open_row;
		sdm_pkg::sdm_burst_e                               bst;
		logic [sdm_pkg::BA_W-1:0]                          bbank;
		logic [sdm_pkg::COL_W-1:0]                         bcol;
		logic [2:0]                                        bleft;
		logic                                              bap;
		logic                                              rd_pend;
		logic [sdm_pkg::DQ_W-1:0]                          dq_out;
		logic [sdm_pkg::DQ_W-1:0]                          oe_n;
		logic [sdm_pkg::ADDR_W-1:0]                        mode;
		logic [7:0]                                        ctrl;
		logic [15:0]                                       masked_cnt;
		logic                                              aw_held;
		logic [sdm_pkg::AXI_AW-1:0]                        awaddr;
		logic                                              w_held;
		logic [31:0]                                       wdata;
		logic [3:0]                                        wstrb;
		logic                                              awready;
		logic                                              wready;
		logic                                              bvalid;
		logic [1:0]                                        bresp;
		logic                                              arready;
		logic                                              h_v;
		logic [33:0]                                       h_d;
		logic                                              t_v;
		logic [33:0]                                       t_d;
	} sdm_state_s;

	sdm_state_s           s_reg;
	sdm_state_s           s_next;
	sdm_pkg::sdm_cmd_e    cmd;
	logic [2:0]           bl_m;

	sdm_mem_if mif ();

	sdm_mem u_mem (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.mif    (mif)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Spreads one mask bit per lane over that lane's data bits
	function automatic logic [sdm_pkg::DQ_W-1:0] lane_expand(
			input logic [sdm_pkg::LANES-1:0] m);
		logic [sdm_pkg::DQ_W-1:0] r;
		r = '0;
		for (int l = 0; l < sdm_pkg::LANES; l++) begin
			r[l*sdm_pkg::LANE_W +: sdm_pkg::LANE_W] = {sdm_pkg::LANE_W{m[l]}};
		end
		return r;
	endfunction

	// Next column inside the burst's wrap window
	function automatic logic [sdm_pkg::COL_W-1:0] col_step(
			input logic [sdm_pkg::COL_W-1:0] c, input logic [2:0] m);
		logic [sdm_pkg::COL_W-1:0] mm;
		mm = {6'h00, m};
		return (c & ~mm) | ((c + 9'h001) & mm);
	endfunction

	// Array address from bank, open row and column
	function automatic logic [sdm_pkg::MEM_AW-1:0] mem_addr(input sdm_state_s st,
			input logic [sdm_pkg::BA_W-1:0] b, input logic [sdm_pkg::COL_W-1:0] c);
		return {b, st.open_row[b][sdm_pkg::MEM_ROW_W-1:0], c[sdm_pkg::MEM_COL_W-1:0]};
	endfunction

	// Register read answer {resp, data}
	function automatic logic [33:0] reg_read(input sdm_state_s st,
			input logic [sdm_pkg::AXI_AW-1:0] a);
		logic [33:0] r;
		r = {sdm_pkg::RESP_SLVERR, 32'h0000_0000};
		unique case (a)
			sdm_pkg::REG_CTRL:   r = {sdm_pkg::RESP_OKAY, 24'h00_0000, st.ctrl};
			sdm_pkg::REG_STATUS: r = {sdm_pkg::RESP_OKAY, 26'h000_0000, st.bst, st.active};
			sdm_pkg::REG_MODE:   r = {sdm_pkg::RESP_OKAY, 20'h0_0000, st.mode};
			sdm_pkg::REG_MASKED: r = {sdm_pkg::RESP_OKAY, 16'h0000, st.masked_cnt};
			default:             r = {sdm_pkg::RESP_SLVERR, 32'h0000_0000};
		endcase
		return r;
	endfunction

	// Registered command; deselect or disable gives no-op
	assign cmd  = (s_reg.cs_n || !s_reg.ctrl[sdm_pkg::CTRL_EN]) ? sdm_pkg::CMD_NOP :
		sdm_pkg::sdm_decode(s_reg.ras_n, s_reg.cas_n, s_reg.we_n);
	assign bl_m = sdm_pkg::sdm_bl_mask(s_reg.ctrl[sdm_pkg::CTRL_BL_MSB:sdm_pkg::CTRL_BL_LSB]);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next      = s_reg;
		mif.we      = 1'b0;
		mif.lane_we = '0;
		mif.waddr   = '0;
		mif.wdata   = s_reg.dq;
		mif.re      = 1'b0;
		mif.raddr   = '0;

		// Pin capture on every rising edge
		s_next.cs_n  = i_cs_n;
		s_next.ras_n = i_ras_n;
		s_next.cas_n = i_cas_n;
		s_next.we_n  = i_we_n;
		s_next.ba    = i_ba;
		s_next.addr  = i_addr;
		s_next.dqm   = {i_high_lane_mask, i_low_lane_mask};
		s_next.dq    = i_dq;

		// Read output stage; mask delayed to two clocks
		s_next.dqm_d1  = s_reg.dqm;
		s_next.rd_pend = 1'b0;
		s_next.dq_out  = s_reg.rd_pend ? mif.rdata : s_reg.dq_out;
		s_next.oe_n    = s_reg.rd_pend ? lane_expand(s_reg.dqm_d1) : 16'hFFFF;

		// Burst in progress runs on regardless of chip select
		unique case (s_reg.bst)
			sdm_pkg::BS_IDLE: begin
			end
			sdm_pkg::BS_READ: begin
				mif.re         = 1'b1;
				mif.raddr      = mem_addr(s_reg, s_reg.bbank, s_reg.bcol);
				s_next.rd_pend = 1'b1;
			end
			sdm_pkg::BS_WRITE: begin
				mif.we      = 1'b1;
				mif.lane_we = ~s_reg.dqm;
				mif.waddr   = mem_addr(s_reg, s_reg.bbank, s_reg.bcol);
			end
		endcase
		if (s_reg.bst != sdm_pkg::BS_IDLE) begin
			s_next.bcol  = col_step(s_reg.bcol, bl_m);
			s_next.bleft = s_reg.bleft - 3'h1;
			if (s_reg.bleft == 3'h1) begin
				s_next.bst = sdm_pkg::BS_IDLE;
				if (s_reg.bap) begin
					s_next.active[s_reg.bbank] = 1'b0;
				end
			end
		end

		// Command decode; a new read or write cuts the burst short
		unique case (cmd)
			sdm_pkg::CMD_ACT: begin
				s_next.active[s_reg.ba]   = 1'b1;
				s_next.open_row[s_reg.ba] = s_reg.addr;
			end
			sdm_pkg::CMD_RD, sdm_pkg::CMD_WR: begin
				s_next.bbank = s_reg.ba;
				s_next.bap   = s_reg.addr[sdm_pkg::AP_BIT];
				s_next.bcol  = col_step(s_reg.addr[sdm_pkg::COL_W-1:0], bl_m);
				s_next.bleft = bl_m;
				if (bl_m == 3'h0) begin
					s_next.bst = sdm_pkg::BS_IDLE;
					if (s_reg.addr[sdm_pkg::AP_BIT]) begin
						s_next.active[s_reg.ba] = 1'b0;
					end
				end else begin
					s_next.bst = (cmd == sdm_pkg::CMD_RD) ? sdm_pkg::BS_READ :
						sdm_pkg::BS_WRITE;
				end
				if (cmd == sdm_pkg::CMD_RD) begin
					mif.we         = 1'b0;
					mif.re         = 1'b1;
					mif.raddr      = mem_addr(s_reg, s_reg.ba,
						s_reg.addr[sdm_pkg::COL_W-1:0]);
					s_next.rd_pend = 1'b1;
				end else begin
					mif.re         = 1'b0;
					mif.we         = 1'b1;
					mif.lane_we    = ~s_reg.dqm;
					mif.waddr      = mem_addr(s_reg, s_reg.ba,
						s_reg.addr[sdm_pkg::COL_W-1:0]);
					s_next.rd_pend = 1'b0;
				end
			end
			sdm_pkg::CMD_PRE: begin
				if (s_reg.addr[sdm_pkg::AP_BIT]) begin
					s_next.active = '0;
				end else begin
					s_next.active[s_reg.ba] = 1'b0;
				end
			end
			sdm_pkg::CMD_LMR: begin
				s_next.mode = s_reg.addr;
			end
			sdm_pkg::CMD_BST: begin
				s_next.bst = sdm_pkg::BS_IDLE;
			end
			sdm_pkg::CMD_REF, sdm_pkg::CMD_NOP: begin
			end
		endcase

		// AXI4-Lite write: address and data taken in either order
		if (i_s_axi_awvalid && s_reg.awready) begin
			s_next.aw_held = 1'b1;
			s_next.awaddr  = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && s_reg.wready) begin
			s_next.w_held = 1'b1;
			s_next.wdata  = i_s_axi_wdata;
			s_next.wstrb  = i_s_axi_wstrb;
		end
		if (s_reg.bvalid && i_s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
			s_next.aw_held = 1'b0;
			s_next.w_held  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = sdm_pkg::RESP_OKAY;
			unique case (s_reg.awaddr)
				sdm_pkg::REG_CTRL: begin
					if (s_reg.wstrb[0]) begin
						s_next.ctrl = s_reg.wdata[7:0];
					end
				end
				sdm_pkg::REG_MASKED: begin
					s_next.masked_cnt = 16'h0000;
				end
				sdm_pkg::REG_STATUS, sdm_pkg::REG_MODE: begin
				end
				default: begin
					s_next.bresp = sdm_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_next.awready = !s_next.aw_held && !s_next.bvalid;
		s_next.wready  = !s_next.w_held && !s_next.bvalid;

		// Masked write beats; a count beats a same-cycle clear
		if (mif.we && (s_reg.dqm != 2'h0)) begin
			s_next.masked_cnt = s_reg.masked_cnt + 16'h0001;
		end

		// Two-entry read answer buffer; a full buffer drops arready
		if (s_reg.h_v && i_s_axi_rready) begin
			if (s_reg.t_v) begin
				s_next.h_d = s_reg.t_d;
				s_next.t_v = 1'b0;
			end else begin
				s_next.h_v = 1'b0;
			end
		end
		if (i_s_axi_arvalid && s_reg.arready) begin
			if (!s_next.h_v) begin
				s_next.h_v = 1'b1;
				s_next.h_d = reg_read(s_reg, i_s_axi_araddr);
			end else begin
				s_next.t_v = 1'b1;
				s_next.t_d = reg_read(s_reg, i_s_axi_araddr);
			end
		end
		s_next.arready = !s_next.t_v;
	end

	// State register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_reg         <= '0;
			s_reg.cs_n    <= 1'b1;
			s_reg.ras_n   <= 1'b1;
			s_reg.cas_n   <= 1'b1;
			s_reg.we_n    <= 1'b1;
			s_reg.oe_n    <= 16'hFFFF;
			s_reg.ctrl    <= sdm_pkg::CTRL_RST;
			s_reg.awready <= 1'b1;
			s_reg.wready  <= 1'b1;
			s_reg.arready <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_dq            = s_reg.dq_out;
	assign o_dq_oe_n       = s_reg.oe_n;
	assign o_s_axi_awready = s_reg.awready;
	assign o_s_axi_wready  = s_reg.wready;
	assign o_s_axi_bvalid  = s_reg.bvalid;
	assign o_s_axi_bresp   = s_reg.bresp;
	assign o_s_axi_arready = s_reg.arready;
	assign o_s_axi_rvalid  = s_reg.h_v;
	assign o_s_axi_rdata   = s_reg.h_d[31:0];
	assign o_s_axi_rresp   = s_reg.h_d[33:32];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	logic [sdm_pkg::BANKS-1:0] pre_sel;
	assign pre_sel = 4'h1 << s_reg.ba;

	sequence seq_rd_unmasked;
		cmd == sdm_pkg::CMD_RD && s_reg.dqm == 2'h0;
	endsequence

	sequence seq_rd_drive;
		o_dq_oe_n == 16'h0000 && o_dq == $past(mif.rdata);
	endsequence

	chk_write_mask_pin: assert property (
		($past(i_high_lane_mask) && mif.we) |-> !mif.lane_we[1])
		else $error("masked high lane written");
	chk_read_hiz_high: assert property (
		s_reg.dqm[1] |-> ##2 o_dq_oe_n[15:8] == 8'hFF)
		else $error("high lane driven despite read mask");
	chk_read_hiz_low: assert property (
		s_reg.dqm[0] |-> ##2 o_dq_oe_n[7:0] == 8'hFF)
		else $error("low lane driven despite read mask");
	chk_read_latency: assert property (
		seq_rd_unmasked |-> ##2 seq_rd_drive)
		else $error("read data not driven two clocks after read");
	chk_row_open: assert property (
		cmd == sdm_pkg::CMD_ACT |=> s_reg.active[$past(s_reg.ba)] &&
			s_reg.open_row[$past(s_reg.ba)] == $past(s_reg.addr))
		else $error("activate did not open the addressed row");
	chk_column_addr: assert property (
		cmd == sdm_pkg::CMD_RD |-> mif.re && mif.raddr[7:6] == s_reg.ba &&
			mif.raddr[3:0] == s_reg.addr[3:0])
		else $error("read column or bank wrong");
	chk_autopre_single: assert property (
		(cmd == sdm_pkg::CMD_RD && s_reg.addr[sdm_pkg::AP_BIT] && bl_m == 3'h0)
			|=> !s_reg.active[$past(s_reg.ba)])
		else $error("auto precharge did not close the bank");
	chk_pre_all: assert property (
		(cmd == sdm_pkg::CMD_PRE && s_reg.addr[sdm_pkg::AP_BIT]) |=> s_reg.active == 4'h0)
		else $error("precharge all left a bank open");
	chk_pre_one: assert property (
		(cmd == sdm_pkg::CMD_PRE && !s_reg.addr[sdm_pkg::AP_BIT] &&
			s_reg.bst == sdm_pkg::BS_IDLE)
			|=> (s_reg.active & ~$past(pre_sel)) == ($past(s_reg.active) & ~$past(pre_sel))
			&& (s_reg.active & $past(pre_sel)) == 4'h0)
		else $error("single precharge touched the wrong bank");
	chk_mode_load: assert property (
		cmd == sdm_pkg::CMD_LMR |=> s_reg.mode == $past(s_reg.addr))
		else $error("mode opcode not taken from address");
	chk_deselect_hold: assert property (
		(s_reg.cs_n && s_reg.bst == sdm_pkg::BS_IDLE) |=> $stable(s_reg.active) &&
			$stable(s_reg.mode))
		else $error("command acted while deselected");

endmodule // sdm_pins

// File: tb/sdm_ctl_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Controller side of the pin link
// ----------------------------------------------------------------
module sdm_ctl_model (
	input  wire logic                        i_clk,
	output logic                             o_cs_n,
	output logic [2:0]                       o_cmd,
	output logic [sdm_pkg::BA_W-1:0]         o_ba,
	output logic [sdm_pkg::ADDR_W-1:0]       o_addr,
	output logic [sdm_pkg::LANES-1:0]        o_lane_mask,
	output logic [sdm_pkg::DQ_W-1:0]         o_dq
);
	// Idle: deselected no-op, masks low
	initial begin
		o_cs_n = 1'b1;
		o_cmd = 3'h7;
		o_ba = 2'h0;
		o_addr = 12'h000;
		o_lane_mask = 2'h0;
		o_dq = 16'h0000;
	end

	// One command; bit 0 of the mask is the low lane, bit 1 the high lane
	task automatic cmd(input logic cs_n, input sdm_pkg::sdm_cmd_e c, input logic [1:0] ba,
			input logic [11:0] a, input logic [1:0] m, input logic [15:0] d);
		@(posedge i_clk);
		o_cs_n <= cs_n;
		o_cmd <= c;
		o_ba <= ba;
		o_addr <= a;
		o_lane_mask <= m;
		o_dq <= d;
		@(posedge i_clk);
		o_cs_n <= 1'b1;
		o_cmd <= sdm_pkg::CMD_NOP;
		o_lane_mask <= 2'h0;
		o_dq <= ~d; // Released data shows the inverse
	endtask
endmodule // sdm_ctl_model

// File: tb/tb_sdram_mask_address_pins.sv
`timescale 1ns/10ps

module tb_sdram_mask_address_pins;
	logic        i_clk, i_nrst, cs_n, awv, wv, bry, arv, rry;
	logic        awr, wr, bv, arr, rv;
	logic [2:0]  cmd;
	logic [1:0]  ba, msk, bresp, rresp, r;
	logic [11:0] addr;
	logic [15:0] host_dq, o_dq, oe_n, dq_w;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, d;
	int          err_total, n_tests;

	// Wire level: device drives lanes whose enable is low
	assign dq_w = (oe_n & host_dq) | (~oe_n & o_dq);

	// Clock, 50 ns period
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	sdm_ctl_model ctl (.i_clk(i_clk), .o_cs_n(cs_n), .o_cmd(cmd), .o_ba(ba), .o_addr(addr),
		.o_lane_mask(msk), .o_dq(host_dq));
	sdm_pins dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_ras_n(cmd[2]),
		.i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba), .i_addr(addr),
		.i_low_lane_mask(msk[0]), .i_high_lane_mask(msk[1]), .i_dq(dq_w), .o_dq(o_dq),
		.o_dq_oe_n(oe_n), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bv),
		.i_s_axi_bready(bry), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(arr), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(rry), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp));

	// Verdict and end of run
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// Bounded wait ran out
	task automatic tmo(input int n);
		if (n >= 50) begin
			err_total++;
			complete_run();
		end
	endtask

	// AXI4-Lite write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge i_clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= v;
		bry <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (bv) break;
		end
		bry <= 1'b0;
		r = bresp;
		tmo(n);
	endtask

	// AXI4-Lite read
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge i_clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rry <= 1'b0;
		d = rdat;
		r = rresp;
		tmo(n);
	endtask

	// Read one word and judge the wire two clocks after the command
	task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
			input logic [15:0] e, input logic [15:0] eo);
		ctl.cmd(1'b0, sdm_pkg::CMD_RD, b, a, m, 16'h0000);
		repeat (2) @(posedge i_clk);
		#1;
		chk(dq_w, e);
		chk(oe_n, eo);
	endtask

	// Masked lane keeps stored byte, mask acts on its own word
	task automatic t_mask;
		ctl.cmd(1'b0, sdm_pkg::CMD_ACT, 2'h1, 12'h002, 2'h0, 16'h0000);
		ctl.cmd(1'b0, sdm_pkg::CMD_WR, 2'h1, 12'h003, 2'h0, 16'ha5c3);
		ctl.cmd(1'b0, sdm_pkg::CMD_WR, 2'h1, 12'h003, 2'h1, 16'h1234);
		rd(2'h1, 12'h003, 2'h0, 16'h12c3, 16'h0000);
		rd(2'h1, 12'h003, 2'h2, 16'hffc3, 16'hff00);
		ctl.cmd(1'b1, sdm_pkg::CMD_WR, 2'h1, 12'h003, 2'h0, 16'hdead);
		rd(2'h1, 12'h003, 2'h0, 16'h12c3, 16'h0000);
		ctl.cmd(1'b0, sdm_pkg::CMD_ACT, 2'h2, 12'h002, 2'h0, 16'h0000);
		ctl.cmd(1'b0, sdm_pkg::CMD_WR, 2'h2, 12'h003, 2'h0, 16'h0f0f);
		rd(2'h1, 12'h003, 2'h0, 16'h12c3, 16'h0000);
		rd(2'h2, 12'h003, 2'h0, 16'h0f0f, 16'h0000);
		$display("t_mask done");
	endtask

	// Registers: status, mode opcode, masked count, control, unmapped
	task automatic t_regs;
		axi_rd(sdm_pkg::REG_STATUS);
		chk(d & 32'h0000_003f, 32'h0000_0006);
		ctl.cmd(1'b0, sdm_pkg::CMD_LMR, 2'h0, 12'h023, 2'h0, 16'h0000);
		axi_rd(sdm_pkg::REG_MODE);
		chk(d, 32'h0000_0023);
		axi_rd(sdm_pkg::REG_MASKED);
		chk(d, 32'h0000_0001);
		axi_wr(sdm_pkg::REG_MASKED, 32'h0000_0000);
		chk(r, sdm_pkg::RESP_OKAY);
		axi_rd(sdm_pkg::REG_MASKED);
		chk(d, 32'h0000_0000);
		axi_wr(sdm_pkg::REG_CTRL, 32'h0000_0003);
		axi_rd(sdm_pkg::REG_CTRL);
		chk(d, 32'h0000_0003);
		axi_wr(sdm_pkg::REG_CTRL, 32'h0000_0001);
		axi_rd(8'h10);
		chk({d[29:0], r}, {30'h0000_0000, sdm_pkg::RESP_SLVERR});
		axi_wr(8'h10, 32'h0000_0000);
		chk(r, sdm_pkg::RESP_SLVERR);
		$display("t_regs done");
	endtask

	// Outputs, handshake readies and control register straight after reset
	task automatic t_reset;
		chk(oe_n, 16'hffff);
		chk({awr, wr, arr, bv, rv}, 32'h0000_001c);
		axi_rd(sdm_pkg::REG_CTRL);
		chk(d, 32'h0000_0001);
		$display("t_reset done");
	endtask

	// Two-beat bursts; second beat runs deselected, read wraps the column
	task automatic t_burst;
		axi_wr(sdm_pkg::REG_CTRL, 32'h0000_0003);
		chk(r, sdm_pkg::RESP_OKAY);
		ctl.cmd(1'b0, sdm_pkg::CMD_WR, 2'h1, 12'h004, 2'h0, 16'h5a5a);
		rd(2'h1, 12'h005, 2'h0, 16'ha5a5, 16'h0000);
		@(posedge i_clk);
		#1;
		chk(dq_w, 16'h5a5a);
		chk(oe_n, 16'h0000);
		axi_wr(sdm_pkg::REG_CTRL, 32'h0000_0001);
		$display("t_burst done");
	endtask

	// Single precharge, auto precharge, precharge all
	task automatic t_pre;
		ctl.cmd(1'b0, sdm_pkg::CMD_PRE, 2'h1, 12'h000, 2'h0, 16'h0000);
		axi_rd(sdm_pkg::REG_STATUS);
		chk(d & 32'h0000_003f, 32'h0000_0004);
		ctl.cmd(1'b0, sdm_pkg::CMD_RD, 2'h2, 12'h403, 2'h0, 16'h0000);
		repeat (4) @(posedge i_clk);
		axi_rd(sdm_pkg::REG_STATUS);
		chk(d & 32'h0000_003f, 32'h0000_0000);
		ctl.cmd(1'b0, sdm_pkg::CMD_ACT, 2'h0, 12'h001, 2'h0, 16'h0000);
		ctl.cmd(1'b0, sdm_pkg::CMD_ACT, 2'h3, 12'h001, 2'h0, 16'h0000);
		ctl.cmd(1'b0, sdm_pkg::CMD_PRE, 2'h0, 12'h400, 2'h0, 16'h0000);
		axi_rd(sdm_pkg::REG_STATUS);
		chk(d & 32'h0000_003f, 32'h0000_0000);
		$display("t_pre done");
	endtask

	// Main sequence
	initial begin
		err_total = 0;
		n_tests = 0;
		i_nrst = 1'b0;
		{awv, wv, bry, arv, rry} = 5'h00;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0000_0000;
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'b1;
		#1;
		t_reset();
		t_mask();
		t_regs();
		t_burst();
		t_pre();
		complete_run();
	end
endmodule // tb_sdram_mask_address_pins
